// ==== sim/aps_partner.sv ====
// behavioural model of one switched supply and the load hanging on it
`timescale 1ns/1ps
`default_nettype none

module aps_partner (
   // clock
   input wire logic i_clk,
   // supply switch and the sample taken by the load
   input wire logic i_pwr,
   input wire logic i_sample,
   // cycles powered before the last sample, cycles unpowered in the last period
   output logic [31:0] o_on_run,
   output logic [31:0] o_off_cnt
);
   logic [31:0] on_cnt; // cycles the load has been powered without a break
   logic [31:0] off_cnt; // cycles without power since the last sample

   // the load only reads correctly after a full unbroken warm-up, so track the run
   // no reset: counts settle at the first sample, and every check waits for several
   always_ff @(posedge i_clk) begin
      if (i_pwr) begin
         on_cnt <= on_cnt + 32'h1;
      end else begin
         on_cnt <= 32'h0;
      end
      if (i_sample) begin
         o_on_run <= on_cnt;
         o_off_cnt <= off_cnt;
         off_cnt <= 32'(!i_pwr);
      end else if (!i_pwr) begin
         off_cnt <= off_cnt + 32'h1;
      end
   end
endmodule

`default_nettype wire

// ==== sim/aps_top_bench.sv ====
// self-checking bench for the acquisition period scheduler
`timescale 1ns/1ps
`default_nettype none

module aps_top_bench;
   import aps_pkg::*;
   localparam int TK = 4; // short tick keeps the run brief
   logic i_clk, i_rstn, p3, pulse3_seen;
   aps_period_t per;
   logic [3:0] en;
   aps_xdcr_mode_t xm;
   logic [WW-1:0] xw;
   aps_xmtr_mode_t tm;
   aps_ana_pwr_t [N_ANA-1:0] aset;
   logic [N_ANA-1:0][WW-1:0] awarm;
   logic [N_PULSE-1:0] pon, o_pulse_samp, o_pulse_en, o_pulse_set_eff, o_pulse_pwr;
   logic o_log_rec, o_calc_run, o_cfg_invalid, o_xdcr_pwr;
   logic [3:0] o_samp, o_ana_pwr;
   logic [PW-1:0] o_calc_per_log, o_samp_per_calc;
   aps_ana_pwr_t [N_ANA-1:0] o_ana_set_eff;
   logic [31:0] x_on, x_off, a_on, a_off;
   int n_fail, checks, cyc, n;

   aps_top #(.N_IN(4), .TICK_CYCLES(TK)) DUT (.i_clk(i_clk), .i_rstn(i_rstn), .i_per(per),
      .i_input_en(en), .i_pulse3_en(p3), .i_xdcr_mode(xm), .i_xdcr_warm(xw), .i_xmtr_mode(tm),
      .i_ana_set(aset), .i_ana_warm(awarm), .i_pulse_on(pon), .o_log_rec(o_log_rec),
      .o_calc_run(o_calc_run), .o_samp(o_samp), .o_pulse_samp(o_pulse_samp), .o_pulse_en(o_pulse_en),
      .o_calc_per_log(o_calc_per_log), .o_samp_per_calc(o_samp_per_calc), .o_cfg_invalid(o_cfg_invalid),
      .o_ana_set_eff(o_ana_set_eff), .o_pulse_set_eff(o_pulse_set_eff), .o_xdcr_pwr(o_xdcr_pwr),
      .o_ana_pwr(o_ana_pwr), .o_pulse_pwr(o_pulse_pwr));
   // transducer supply and analog supply 3 both serve loads sampled with input 0
   aps_partner u_xdcr (.i_clk(i_clk), .i_pwr(o_xdcr_pwr), .i_sample(o_samp[0]), .o_on_run(x_on), .o_off_cnt(x_off));
   aps_partner u_ana (.i_clk(i_clk), .i_pwr(o_ana_pwr[3]), .i_sample(o_samp[0]), .o_on_run(a_on), .o_off_cnt(a_off));

   // clock at 200 MHz
   initial begin
      i_clk = 1'b0;
      forever #2.5 i_clk = ~i_clk;
   end

   // hang guard: a count well above the whole sequence
   always @(posedge i_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         end_of_test();
      end
   end

   // pulse 3 strobe watcher, a bit of the strobe must never show while disabled
   always @(negedge i_clk) begin
      if (o_pulse_samp[2] === 1'b1) begin
         pulse3_seen = 1'b1;
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch at %0t seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   // strobe selected by index, sampled at the falling edge where it is settled
   function automatic logic strobe(input int k);
      case (k)
         0: return o_samp[0];
         1: return o_calc_run;
         2: return o_log_rec;
         3: return o_pulse_samp[0];
         default: return o_samp[1];
      endcase
   endfunction

   // cycles until the next strobe; bounded so a dead strobe cannot hang the run
   task automatic wait_pulse(input int k, output int c);
      c = 0;
      do begin
         @(negedge i_clk);
         c++;
      end while (strobe(k) !== 1'b1 && c < 1000);
   endtask

   task automatic idle(input int c);
      repeat (c) @(negedge i_clk);
   endtask

   task automatic t_reset();
      chk(32'(o_pulse_en), 32'h3);
      idle(60);
      chk(32'(o_calc_per_log), 32'h2);
      chk(32'(o_samp_per_calc), 32'h5);
      chk(32'(o_cfg_invalid), 32'h0);
      $display("test reset done");
   endtask

   // interval between two strobes of each kind, in clock cycles
   task automatic t_periods();
      int exp [4] = '{2 * TK, 10 * TK, 20 * TK, 10 * TK};
      for (int k = 0; k < 4; k++) begin
         wait_pulse(k, n);
         wait_pulse(k, n);
         chk(32'(n), 32'(exp[k]));
      end
      $display("test periods done");
   endtask

   // sampling period beyond the calculation period is flagged
   task automatic t_invalid();
      per.samp_p = 19'h14;
      idle(60);
      chk(32'(o_cfg_invalid), 32'h1);
      chk(32'(o_samp_per_calc), 32'h0);
      per.samp_p = 19'hA;
      idle(60);
      chk(32'(o_cfg_invalid), 32'h0);
      chk(32'(o_samp_per_calc), 32'h1);
      // zero picks the defaults: one minute calculation, one second sampling
      per.calc_p = 19'h0;
      per.samp_p = 19'h0;
      idle(60);
      chk(32'(o_samp_per_calc), 32'h3C);
      chk(32'(o_calc_per_log), 32'h0);
      chk(32'(o_cfg_invalid), 32'h0);
      per.calc_p = 19'hA;
      per.samp_p = 19'h2;
      $display("test invalid done");
   endtask

   // cleared enables suppress strobes; pulse 3 only once enabled
   task automatic t_enable();
      en = 4'hD;
      pulse3_seen = 1'b0;
      wait_pulse(5, n);
      chk(32'(n), 32'h3E8);
      chk(32'(pulse3_seen), 32'h0);
      en = 4'hF;
      p3 = 1'b1;
      idle(2);
      chk(32'(o_pulse_en), 32'h7);
      wait_pulse(5, n);
      chk(32'(n <= 2 * TK + 1), 32'h1);
      pulse3_seen = 1'b0;
      idle(10 * TK + 2);
      chk(32'(pulse3_seen), 32'h1);
      $display("test enable done");
   endtask

   // warm-up excitation: short warm-up gaps the supply, long warm-up keeps it on
   task automatic t_warm();
      per.samp_p = 19'h4;
      xm = XDCR_WARM_UP;
      xw = 13'h1;
      repeat (3) wait_pulse(0, n);
      idle(2);
      chk(32'(x_on >= TK - 1 && x_on < 4 * TK), 32'h1);
      chk(32'(x_off > 0), 32'h1);
      xw = 13'h6;
      repeat (3) wait_pulse(0, n);
      idle(2);
      chk(x_off, 32'h0);
      xm = XDCR_ALWAYS_ON;
      $display("test warm done");
   endtask

   // transmitter supplies under both global modes
   task automatic t_xmtr();
      aset = '{ANA_WARM, ANA_ON, ANA_OFF, aps_ana_pwr_t'(2'h3)};
      awarm[3] = 13'h2;
      pon = 3'h5;
      tm = XMTR_DISABLED;
      idle(3);
      chk(32'(o_ana_set_eff), 32'h0);
      chk(32'({o_pulse_set_eff, o_pulse_pwr, o_ana_pwr}), 32'h0);
      tm = XMTR_IF_REQUIRED;
      repeat (3) wait_pulse(0, n);
      idle(2);
      chk(32'(o_ana_set_eff), 32'h90);
      chk(32'(o_ana_pwr[2:0]), 32'h4);
      chk(32'(o_pulse_pwr), 32'h5);
      chk(32'(a_on >= 2 * TK - 1 && a_on < 4 * TK), 32'h1);
      chk(32'(a_off > 0), 32'h1);
      tm = XMTR_DISABLED;
      idle(3);
      chk(32'({o_ana_pwr, o_pulse_pwr}), 32'h0);
      $display("test xmtr done");
   endtask

   task automatic end_of_test();
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // main sequence, inputs change at the falling edge
   initial begin
      n_fail = 0;
      checks = 0;
      cyc = 0;
      i_rstn = 1'b0;
      per = '{log_p: 19'h14, calc_p: 19'hA, samp_p: 19'h2};
      en = 4'hF;
      p3 = 1'b0;
      xm = XDCR_ALWAYS_ON;
      xw = 13'h1;
      tm = XMTR_IF_REQUIRED;
      aset = '{default: ANA_OFF};
      awarm = '{default: 13'h1};
      pon = 3'h0;
      pulse3_seen = 1'b0;
      idle(10);
      i_rstn = 1'b1;
      t_reset();
      t_periods();
      t_invalid();
      t_enable();
      t_warm();
      t_xmtr();
      end_of_test();
   end
endmodule

`default_nettype wire

// ==== src/aps_pkg.sv ====
// shared constants and types for the acquisition period scheduler
package aps_pkg;
   // clock and timebase: all periods count 0.1 s ticks
   localparam int CLK_NS = 5;
   localparam int TICK_NS = 100_000_000;
   localparam int TICK_CYC = TICK_NS / CLK_NS;
   // field widths of period and warm-up values, in ticks
   localparam int PW = 19;
   localparam int WW = 13;
   // period limits and defaults, in ticks
   localparam int HOUR_S = 3600;
   localparam logic [PW-1:0] MAX_PER_TK = PW'(12 * HOUR_S * 10);
   localparam logic [PW-1:0] MIN_LOG_TK = PW'(10);
   localparam logic [PW-1:0] MIN_CALC_TK = PW'(10);
   localparam logic [PW-1:0] MIN_SAMP_TK = PW'(1);
   localparam logic [PW-1:0] DEF_LOG_TK = PW'(HOUR_S * 10);
   localparam logic [PW-1:0] DEF_CALC_TK = PW'(60 * 10);
   localparam logic [PW-1:0] DEF_SAMP_TK = PW'(10);
   // fixed pulse input rate: one second
   localparam logic [PW-1:0] PULSE_TK = PW'(10);
   // warm-up limits, in ticks (0.1 s .. 10 min)
   localparam logic [WW-1:0] MIN_WARM_TK = WW'(1);
   localparam logic [WW-1:0] MAX_WARM_TK = WW'(10 * 60 * 10);
   // supply counts
   localparam int N_PULSE = 3;
   localparam int N_ANA = 4;
   // configured periods travel together
   typedef struct packed {
      logic [PW-1:0] log_p;
      logic [PW-1:0] calc_p;
      logic [PW-1:0] samp_p;
   } aps_period_t;
   // integrated transducer excitation
   typedef enum logic {
      XDCR_ALWAYS_ON = 1'h0,
      XDCR_WARM_UP = 1'h1
   } aps_xdcr_mode_t;
   // global transmitter power mode
   typedef enum logic {
      XMTR_DISABLED = 1'h0,
      XMTR_IF_REQUIRED = 1'h1
   } aps_xmtr_mode_t;
   // per analog transmitter setting; code 3 acts as off
   typedef enum logic [1:0] {
      ANA_OFF = 2'h0,
      ANA_ON = 2'h1,
      ANA_WARM = 2'h2
   } aps_ana_pwr_t;
endpackage

// ==== src/aps_top.sv ====
// acquisition period scheduler: counters, ratio dividers, excitation control
`timescale 1ns/1ps
`default_nettype none

// free-running tick counter that wraps once per period
module aps_pcnt #(
   parameter int W = 19
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rstn,
   // tick and period
   input wire logic i_tick,
   input wire logic [W-1:0] i_period,
   // count and wrap
   output logic [W-1:0] o_cnt,
   output logic o_wrap
);
   // wrap on the tick that ends the period; >= survives a shortened period
   assign o_wrap = i_tick && (o_cnt >= i_period - W'(1));

   // count ticks
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_cnt <= '0;
      end else if (o_wrap) begin
         o_cnt <= '0;
      end else if (i_tick) begin
         o_cnt <= o_cnt + W'(1);
      end
   end
endmodule

// free-running restoring divider, refreshes the quotient every W+1 cycles
module aps_div #(
   parameter int W = 19
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rstn,
   // operands, denominator never zero
   input wire logic [W-1:0] i_num,
   input wire logic [W-1:0] i_den,
   // quotient
   output logic [W-1:0] o_q
);
   localparam int CW = $clog2(W + 1);
   logic [CW-1:0] step; // 0 loads operands
   logic [W-1:0] rem; // partial remainder
   logic [W-1:0] quo; // dividend shifting into quotient
   logic [W-1:0] den; // held denominator
   logic [W:0] sh; // remainder with next bit
   logic ge; // subtract succeeds
   logic [W:0] diff; // remainder after subtract

   // one restoring step
   always_comb begin
      sh = {rem, quo[W-1]};
      ge = (sh >= {1'b0, den});
      diff = sh - {1'b0, den};
   end

   // iterate; quotient lags a config change by at most 2*(W+1) cycles
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         step <= '0;
         rem <= '0;
         quo <= '0;
         den <= '0;
         o_q <= '0;
      end else if (step == '0) begin
         rem <= '0;
         quo <= i_num;
         den <= i_den;
         step <= CW'(1);
      end else begin
         rem <= ge ? diff[W-1:0] : sh[W-1:0];
         quo <= {quo[W-2:0], ge};
         if (step == CW'(W)) begin
            o_q <= {quo[W-2:0], ge};
            step <= '0;
         end else begin
            step <= step + CW'(1);
         end
      end
   end
endmodule

// one supply switched by the warm-up schedule
module aps_warm (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rstn,
   // schedule
   input wire logic [aps_pkg::PW-1:0] i_rem,
   input wire logic [aps_pkg::PW-1:0] i_period,
   input wire logic i_sample,
   // setting
   input wire logic i_on,
   input wire logic i_warm_en,
   input wire logic [aps_pkg::WW-1:0] i_warm,
   // supply switch
   output logic o_pwr
);
   import aps_pkg::*;
   logic [PW-1:0] warm_ext; // warm-up widened to period width

   assign warm_ext = {{(PW-WW){1'b0}}, i_warm};

   // supply state
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_pwr <= 1'b0;
      end else if (!i_warm_en) begin
         o_pwr <= i_on;
      end else if (warm_ext >= i_period) begin
         o_pwr <= 1'b1;
      end else if (i_sample) begin
         o_pwr <= 1'b0;
      end else if (i_rem <= warm_ext) begin
         o_pwr <= 1'b1;
      end
   end
endmodule

// top of the scheduler
module aps_top #(
   parameter int N_IN = 4,
   parameter int TICK_CYCLES = aps_pkg::TICK_CYC
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rstn,
   // periods in 0.1 s ticks, zero selects the default
   input wire aps_pkg::aps_period_t i_per,
   // input enables
   input wire logic [N_IN-1:0] i_input_en,
   input wire logic i_pulse3_en,
   // integrated transducer excitation
   input wire aps_pkg::aps_xdcr_mode_t i_xdcr_mode,
   input wire logic [aps_pkg::WW-1:0] i_xdcr_warm,
   // external transmitter power
   input wire aps_pkg::aps_xmtr_mode_t i_xmtr_mode,
   input wire aps_pkg::aps_ana_pwr_t [aps_pkg::N_ANA-1:0] i_ana_set,
   input wire logic [aps_pkg::N_ANA-1:0][aps_pkg::WW-1:0] i_ana_warm,
   input wire logic [aps_pkg::N_PULSE-1:0] i_pulse_on,
   // schedule strobes
   output logic o_log_rec,
   output logic o_calc_run,
   output logic [N_IN-1:0] o_samp,
   output logic [aps_pkg::N_PULSE-1:0] o_pulse_samp,
   // status
   output logic [aps_pkg::N_PULSE-1:0] o_pulse_en,
   output logic [aps_pkg::PW-1:0] o_calc_per_log,
   output logic [aps_pkg::PW-1:0] o_samp_per_calc,
   output logic o_cfg_invalid,
   output aps_pkg::aps_ana_pwr_t [aps_pkg::N_ANA-1:0] o_ana_set_eff,
   output logic [aps_pkg::N_PULSE-1:0] o_pulse_set_eff,
   // supply switches
   output logic o_xdcr_pwr,
   output logic [aps_pkg::N_ANA-1:0] o_ana_pwr,
   output logic [aps_pkg::N_PULSE-1:0] o_pulse_pwr
);
   import aps_pkg::*;
   localparam int TW = $clog2(TICK_CYCLES + 1);

   logic [1:0] rst_sync; // reset release chain
   logic rst_n; // synchronised reset
   logic [TW-1:0] pre; // tick prescaler
   logic tick; // one cycle per 0.1 s
   logic [PW-1:0] log_p, calc_p, samp_p; // clamped periods
   logic [PW-1:0] samp_cnt; // position in sampling period
   logic log_wrap, calc_wrap, samp_wrap, pulse_wrap; // period ends
   logic pulse3_en; // configured pulse 3 enable
   logic [N_ANA:0] w_on, w_en, w_pwr; // index 0 transducer, rest analog
   logic [N_ANA:0][WW-1:0] w_time; // clamped warm-up times

   // clamp a period into range, zero picks the default
   function automatic logic [PW-1:0] clamp_p(input logic [PW-1:0] v, input logic [PW-1:0] lo,
                                             input logic [PW-1:0] dflt);
      if (v == '0) return dflt;
      if (v < lo) return lo;
      if (v > MAX_PER_TK) return MAX_PER_TK;
      return v;
   endfunction

   // clamp a warm-up time into range
   function automatic logic [WW-1:0] clamp_w(input logic [WW-1:0] v);
      if (v < MIN_WARM_TK) return MIN_WARM_TK;
      if (v > MAX_WARM_TK) return MAX_WARM_TK;
      return v;
   endfunction

   // reset: asserted at once, released through two flops
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         rst_sync <= 2'h0;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_n = rst_sync[1];

   // 0.1 s timebase
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         pre <= '0;
      end else if (tick) begin
         pre <= '0;
      end else begin
         pre <= pre + TW'(1);
      end
   end
   assign tick = (pre == TW'(TICK_CYCLES - 1));

   // limits keep every divider and counter away from a zero period
   assign log_p = clamp_p(i_per.log_p, MIN_LOG_TK, DEF_LOG_TK);
   assign calc_p = clamp_p(i_per.calc_p, MIN_CALC_TK, DEF_CALC_TK);
   assign samp_p = clamp_p(i_per.samp_p, MIN_SAMP_TK, DEF_SAMP_TK);

   // period counters, all aligned to the same tick
   aps_pcnt #(.W(PW)) u_log (.i_clk(i_clk), .i_rstn(rst_n), .i_tick(tick), .i_period(log_p),
                             .o_cnt(), .o_wrap(log_wrap));
   aps_pcnt #(.W(PW)) u_calc (.i_clk(i_clk), .i_rstn(rst_n), .i_tick(tick), .i_period(calc_p),
                              .o_cnt(), .o_wrap(calc_wrap));
   aps_pcnt #(.W(PW)) u_samp (.i_clk(i_clk), .i_rstn(rst_n), .i_tick(tick), .i_period(samp_p),
                              .o_cnt(samp_cnt), .o_wrap(samp_wrap));
   aps_pcnt #(.W(PW)) u_pulse (.i_clk(i_clk), .i_rstn(rst_n), .i_tick(tick), .i_period(PULSE_TK),
                               .o_cnt(), .o_wrap(pulse_wrap));

   // derived ratios, truncated when periods do not divide evenly
   aps_div #(.W(PW)) u_cpl (.i_clk(i_clk), .i_rstn(rst_n), .i_num(log_p), .i_den(calc_p),
                            .o_q(o_calc_per_log));
   aps_div #(.W(PW)) u_spc (.i_clk(i_clk), .i_rstn(rst_n), .i_num(calc_p), .i_den(samp_p),
                            .o_q(o_samp_per_calc));

   // pulse 3 enable is held off until configuration turns it on
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         pulse3_en <= 1'b0;
      end else begin
         pulse3_en <= i_pulse3_en;
      end
   end
   assign o_pulse_en = {pulse3_en, 2'h3};

   // strobes and validity flag; invalid settings still run, software must fix them
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_log_rec <= 1'b0;
         o_calc_run <= 1'b0;
         o_samp <= '0;
         o_pulse_samp <= '0;
         o_cfg_invalid <= 1'b0;
      end else begin
         o_log_rec <= log_wrap;
         o_calc_run <= calc_wrap;
         o_samp <= {N_IN{samp_wrap}} & i_input_en;
         o_pulse_samp <= {N_PULSE{pulse_wrap}} & o_pulse_en;
         o_cfg_invalid <= (samp_p > calc_p);
      end
   end

   // supply settings; the global disable overrides every analog and pulse setting, not the transducer
   always_comb begin
      w_on[0] = (i_xdcr_mode == XDCR_ALWAYS_ON);
      w_en[0] = (i_xdcr_mode == XDCR_WARM_UP);
      w_time[0] = clamp_w(i_xdcr_warm);
      for (int i = 0; i < N_ANA; i++) begin
         o_ana_set_eff[i] = ANA_OFF;
         if (i_xmtr_mode == XMTR_IF_REQUIRED && (i_ana_set[i] == ANA_ON || i_ana_set[i] == ANA_WARM)) begin
            o_ana_set_eff[i] = i_ana_set[i];
         end
         w_on[i+1] = (o_ana_set_eff[i] == ANA_ON);
         w_en[i+1] = (o_ana_set_eff[i] == ANA_WARM);
         w_time[i+1] = clamp_w(i_ana_warm[i]);
      end
      // pulse supplies have no warm-up path
      o_pulse_set_eff = (i_xmtr_mode == XMTR_DISABLED) ? '0 : i_pulse_on;
   end

   // transducer and analog supplies share the sampling schedule
   for (genvar g = 0; g <= N_ANA; g++) begin : g_warm
      aps_warm u_warm (
         .i_clk(i_clk),
         .i_rstn(rst_n),
         .i_rem(samp_p - samp_cnt),
         .i_period(samp_p),
         .i_sample(samp_wrap),
         .i_on(w_on[g]),
         .i_warm_en(w_en[g]),
         .i_warm(w_time[g]),
         .o_pwr(w_pwr[g])
      );
   end
   assign o_xdcr_pwr = w_pwr[0];
   assign o_ana_pwr = w_pwr[N_ANA:1];

   // pulse transmitter supplies
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_pulse_pwr <= '0;
      end else begin
         o_pulse_pwr <= o_pulse_set_eff;
      end
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!rst_n);

   property p_log_on_wrap;
      o_log_rec |-> $past(log_wrap) && $past(tick);
   endproperty
   a_log_on_wrap: assert property (p_log_on_wrap) else $error("log record without period end");

   property p_calc_spacing;
      o_calc_run |=> !o_calc_run [*8];
   endproperty
   a_calc_spacing: assert property (p_calc_spacing) else $error("calc runs too close");

   property p_invalid;
      ##1 (o_cfg_invalid == ($past(samp_p) > $past(calc_p)));
   endproperty
   a_invalid: assert property (p_invalid) else $error("validity flag wrong");

   property p_samp_gated;
      (o_samp != '0) |-> $past(samp_wrap) && ((o_samp & ~$past(i_input_en)) == '0);
   endproperty
   a_samp_gated: assert property (p_samp_gated) else $error("disabled input sampled");

   property p_pulse_en;
      (o_pulse_en[1:0] == 2'h3) and (o_pulse_samp[2] |-> $past(pulse3_en));
   endproperty
   a_pulse_en: assert property (p_pulse_en) else $error("pulse enable wrong");

   property p_pulse_rate;
      o_pulse_samp[0] |-> $past(pulse_wrap) ##1 !o_pulse_samp[0] [*8];
   endproperty
   a_pulse_rate: assert property (p_pulse_rate) else $error("pulse sample rate wrong");

   property p_global_off;
      (i_xmtr_mode == XMTR_DISABLED) [*2] |-> o_ana_pwr == '0 && o_pulse_pwr == '0 && o_ana_set_eff == '0;
   endproperty
   a_global_off: assert property (p_global_off) else $error("supply on while disabled");

   property p_warm_release;
      (samp_wrap && w_en[0] && {{(PW-WW){1'b0}}, w_time[0]} < samp_p) ##1 (w_en[0] && $stable(samp_p))
         |-> !o_xdcr_pwr;
   endproperty
   a_warm_release: assert property (p_warm_release) else $error("power held after sample");

   property p_warm_lead;
      (w_en[0] && samp_wrap && $past(w_en[0]) && $stable(samp_p) && $stable(w_time[0])) |-> o_xdcr_pwr;
   endproperty
   a_warm_lead: assert property (p_warm_lead) else $error("unpowered at sample");

   property p_always_on;
      (i_xdcr_mode == XDCR_ALWAYS_ON) |=> o_xdcr_pwr;
   endproperty
   a_always_on: assert property (p_always_on) else $error("transducer not powered");

   c_log: cover property (o_log_rec);
   c_invalid: cover property ($rose(o_cfg_invalid));
   c_warm_cycle: cover property (w_en[0] && $rose(o_xdcr_pwr) ##[1:1000] $fell(o_xdcr_pwr));
   c_pulse3: cover property (o_pulse_samp[2]);
endmodule

`default_nettype wire
